// ---- logic/ipr_defs.svh ----
// Constants for the internal program RAM port: geometry, decode and timing.
// Assumes inclusion by the package and by every design file that needs them.
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// ----------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------
`define IPR_WORDS 1024
`define IPR_AW 10
`define IPR_DW 32
`define IPR_BYTES 4
// Window size in bytes is 4 KB, so the base decode uses bits 31:12
`define IPR_BASE_LSB 12

// ----------------------------------------------------------------
// Base address register layout and reset
// ----------------------------------------------------------------
`define IPR_BAR_RESET 32'h0000_0000
`define IPR_BAR_WMASK 32'hffff_f000

// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define IPR_CHIP_TEST_REG_TWO_MIRROR_BIT 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IPR_MEM_WAIT 3
`define IPR_REG_WAIT 5
`define IPR_SYNC_STAGES 3

`endif

// ---- logic/ipr_pkg.sv ----
// Types shared by the internal program RAM port modules.
// Assumes ipr_defs.svh is on the include path.
`include "ipr_defs.svh"

package ipr_pkg;

    // ----------------------------------------------------------------
    // Kinds of sequencer access
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IPR_FETCH_INSTR,
        IPR_FETCH_TABLE,
        IPR_ACCESS_OTHER
    } ipr_kind_t;

    // ----------------------------------------------------------------
    // Target access states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IPR_T_IDLE,
        IPR_T_WAIT,
        IPR_T_DONE
    } ipr_tstate_t;

endpackage : ipr_pkg

// ---- logic/ipr_ram_if.sv ----
// Carrier between the port controller and the RAM array.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`include "ipr_defs.svh"

interface ipr_ram_if;
    logic en;
    logic we;
    logic [`IPR_BYTES-1:0] be;
    logic [`IPR_AW-1:0] addr;
    logic [`IPR_DW-1:0] wdata;
    logic [`IPR_DW-1:0] rdata;

    modport ctrl (output en, output we, output be, output addr, output wdata, input rdata);
    modport mem (input en, input we, input be, input addr, input wdata, output rdata);
endinterface : ipr_ram_if

// ---- logic/ipr_ram.sv ----
// Single-port 1024 x 32 RAM with byte-lane write enables and registered read.
// Assumes the controller issues at most one operation per clock.
`timescale 1ns/100ps
`include "ipr_defs.svh"

module ipr_ram (
    // Clock
    input wire logic core_clk_i,
    // Controller side
    ipr_ram_if.mem ram
);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [`IPR_DW-1:0] rdata;

    assign ram.rdata = rdata;

    // ----------------------------------------------------------------
    // Byte lanes, each with its own storage, write and read
    // ----------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < `IPR_BYTES; gb++) begin : g_lane
            logic [7:0] lane_mem [0:`IPR_WORDS-1];

            always_ff @(posedge core_clk_i) begin
                if (ram.en && ram.we && ram.be[gb]) begin
                    lane_mem[ram.addr] <= ram.wdata[gb*8 +: 8];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (ram.en && !ram.we) begin
                    rdata[gb*8 +: 8] <= lane_mem[ram.addr];
                end
            end
        end
    endgenerate

endmodule : ipr_ram

// ---- logic/ipr_port.sv ----
// Internal program RAM port: target access, sequencer fetch, base decode.
// Assumes a PCI front end that presents decoded single-word accesses
// and configuration writes on the PCI clock.
//
// Notes on behaviour
// - The block holds 1024 words of 32 bits, 4 KB, for program code or any data.
// - Instruction and table-indirect fetches that hit the RAM are served inside.
// - Any other own access to the RAM range is sent out on PCI like external memory.
// - The strap pin high enables the RAM and low disables it.
// - Software writes the base register and the block decodes accesses at that base.
// - While chip test register two bit 3 is set, scratch register two shows the base.
// - Any PCI master may read and write the RAM with byte granularity.
// - PCI accesses to the RAM take 3 target wait states rather than 5.
`timescale 1ns/100ps
`include "ipr_defs.svh"

module ipr_port (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Strap pin
    input wire logic local_bus_strap_bit5_i,
    // Configuration space access to the base register
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic mem_space_en_i,
    output logic [31:0] cfg_bar_o,
    // Scratch mirror
    input wire logic [7:0] chip_test_reg_two_i,
    input wire logic [31:0] scratch_value_i,
    output logic [31:0] general_scratch_reg_two_o,
    // PCI target access
    input wire logic tgt_req_i,
    input wire logic [31:0] tgt_addr_i,
    input wire logic tgt_we_i,
    input wire logic [3:0] tgt_be_i,
    input wire logic [31:0] tgt_wdata_i,
    output logic tgt_claim_o,
    output logic tgt_busy_o,
    output logic tgt_ready_o,
    output logic [31:0] tgt_rdata_o,
    // Sequencer access
    input wire logic seq_req_i,
    input wire logic [31:0] seq_addr_i,
    input wire ipr_pkg::ipr_kind_t seq_kind_i,
    output logic seq_internal_o,
    output logic seq_to_bus_o,
    output logic seq_ready_o,
    output logic [31:0] seq_rdata_o,
    output logic ram_enabled_o
);

    // ----------------------------------------------------------------
    // Strap synchroniser and capture
    // ----------------------------------------------------------------
    logic [`IPR_SYNC_STAGES-1:0] strap_sync;
    logic [1:0] strap_fill;
    logic strap_taken;
    logic ram_en;

    // Counts edges until every sync stage holds a pin sample
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_fill <= 2'h0;
        end else if (strap_fill != 2'(`IPR_SYNC_STAGES)) begin
            strap_fill <= strap_fill + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_sync <= 3'h0;
        end else begin
            strap_sync <= {strap_sync[1:0], local_bus_strap_bit5_i};
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_taken <= 1'h0;
            ram_en <= 1'h0;
        end else if (!strap_taken && strap_fill == 2'(`IPR_SYNC_STAGES)
            && strap_sync[1] == strap_sync[2]) begin
            strap_taken <= 1'h1;
            ram_en <= strap_sync[2];
        end
    end

    assign ram_enabled_o = ram_en;

    // ----------------------------------------------------------------
    // Base address register
    // ----------------------------------------------------------------
    logic [31:0] bar;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bar <= `IPR_BAR_RESET;
        end else if (cfg_wr_i && ram_en) begin
            bar <= cfg_wdata_i & `IPR_BAR_WMASK;
        end
    end

    assign cfg_bar_o = ram_en ? bar : 32'h0;

    always_comb begin
        if (chip_test_reg_two_i[`IPR_CHIP_TEST_REG_TWO_MIRROR_BIT]) begin
            general_scratch_reg_two_o = cfg_bar_o;
        end else begin
            general_scratch_reg_two_o = scratch_value_i;
        end
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic tgt_hit;
    logic seq_hit;

    assign tgt_hit = ram_en && mem_space_en_i
        && (tgt_addr_i[31:`IPR_BASE_LSB] == bar[31:`IPR_BASE_LSB]);
    assign seq_hit = ram_en && (seq_addr_i[31:`IPR_BASE_LSB] == bar[31:`IPR_BASE_LSB]);

    // ----------------------------------------------------------------
    // Target access sequence
    // ----------------------------------------------------------------
    ipr_pkg::ipr_tstate_t tstate;
    logic [1:0] wcnt;
    logic [`IPR_AW-1:0] t_addr;
    logic t_we;
    logic [3:0] t_be;
    logic [31:0] t_wdata;
    logic t_op;

    assign t_op = (tstate == ipr_pkg::IPR_T_WAIT) && (wcnt == 2'(`IPR_MEM_WAIT - 1));
    assign tgt_claim_o = tgt_req_i && tgt_hit && (tstate == ipr_pkg::IPR_T_IDLE);
    assign tgt_busy_o = (tstate != ipr_pkg::IPR_T_IDLE);
    assign tgt_ready_o = (tstate == ipr_pkg::IPR_T_DONE);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tstate <= ipr_pkg::IPR_T_IDLE;
            wcnt <= 2'h0;
        end else begin
            case (tstate)
                ipr_pkg::IPR_T_IDLE: begin
                    wcnt <= 2'h0;
                    if (tgt_claim_o) begin
                        tstate <= ipr_pkg::IPR_T_WAIT;
                    end
                end
                ipr_pkg::IPR_T_WAIT: begin
                    wcnt <= wcnt + 2'h1;
                    if (t_op) begin
                        tstate <= ipr_pkg::IPR_T_DONE;
                    end
                end
                ipr_pkg::IPR_T_DONE: begin
                    tstate <= ipr_pkg::IPR_T_IDLE;
                end
                default: begin
                    tstate <= ipr_pkg::IPR_T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            t_addr <= 10'h0;
            t_we <= 1'h0;
            t_be <= 4'h0;
            t_wdata <= 32'h0;
        end else if (tgt_claim_o) begin
            t_addr <= tgt_addr_i[`IPR_AW+1:2];
            t_we <= tgt_we_i;
            t_be <= tgt_be_i;
            t_wdata <= tgt_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer access routing
    // ----------------------------------------------------------------
    logic seq_fetch;
    logic seq_go;
    logic seq_pend;

    assign seq_fetch = (seq_kind_i == ipr_pkg::IPR_FETCH_INSTR)
        || (seq_kind_i == ipr_pkg::IPR_FETCH_TABLE);
    assign seq_internal_o = seq_req_i && seq_fetch && seq_hit;
    assign seq_to_bus_o = seq_req_i && !seq_internal_o;
    assign seq_go = seq_internal_o && !t_op && !seq_pend;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_pend <= 1'h0;
        end else begin
            seq_pend <= seq_go;
        end
    end

    assign seq_ready_o = seq_pend;

    // ----------------------------------------------------------------
    // RAM array
    // ----------------------------------------------------------------
    ipr_ram_if ram_bus ();

    always_comb begin
        if (t_op) begin
            ram_bus.en = 1'h1;
            ram_bus.we = t_we;
            ram_bus.be = t_be;
            ram_bus.addr = t_addr;
            ram_bus.wdata = t_wdata;
        end else begin
            ram_bus.en = seq_go;
            ram_bus.we = 1'h0;
            ram_bus.be = 4'h0;
            ram_bus.addr = seq_addr_i[`IPR_AW+1:2];
            ram_bus.wdata = 32'h0;
        end
    end

    ipr_ram u_ram (
        .core_clk_i (core_clk_i),
        .ram (ram_bus.mem)
    );

    assign tgt_rdata_o = ram_bus.rdata;
    assign seq_rdata_o = ram_bus.rdata;

endmodule : ipr_port

// ---- verif/ipr_port_sva.sv ----
// Assertions on the ports of the internal program RAM port.
// Assumes one clock domain; bound to ipr_port at the foot of this file.
`timescale 1ns/100ps

module ipr_port_sva (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Configuration and mirror
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic mem_space_en_i,
    input wire logic [31:0] cfg_bar_o,
    input wire logic [7:0] chip_test_reg_two_i,
    input wire logic [31:0] scratch_value_i,
    input wire logic [31:0] general_scratch_reg_two_o,
    input wire logic ram_enabled_o,
    // Target and sequencer
    input wire logic tgt_req_i,
    input wire logic [31:0] tgt_addr_i,
    input wire logic tgt_claim_o,
    input wire logic tgt_busy_o,
    input wire logic tgt_ready_o,
    input wire logic seq_req_i,
    input wire ipr_pkg::ipr_kind_t seq_kind_i,
    input wire logic seq_internal_o,
    input wire logic seq_to_bus_o,
    input wire logic seq_ready_o
);
    // ----------------------------------------------------------------
    // Port checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_three_wait_states: assert property (tgt_claim_o |=> !tgt_ready_o [*3] ##1 tgt_ready_o)
        else $error("target ready not after three wait states");
    a_busy_span: assert property (tgt_claim_o |=> tgt_busy_o [*4] ##1 !tgt_busy_o)
        else $error("target busy span wrong");
    a_claim_on_hit: assert property (tgt_claim_o |-> tgt_req_i && mem_space_en_i &&
        ram_enabled_o && tgt_addr_i[31:12] == cfg_bar_o[31:12])
        else $error("target claim without a hit");
    a_fetch_internal: assert property (seq_internal_o |-> seq_req_i &&
        seq_kind_i != ipr_pkg::IPR_ACCESS_OTHER && ram_enabled_o)
        else $error("internal service of a non-fetch access");
    a_other_to_bus: assert property (seq_req_i && seq_kind_i == ipr_pkg::IPR_ACCESS_OTHER
        |-> seq_to_bus_o && !seq_internal_o)
        else $error("other access not sent to the bus");
    a_fetch_answer: assert property (seq_ready_o |-> $past(seq_internal_o))
        else $error("sequencer ready without a fetch");
    a_base_write: assert property (cfg_wr_i && ram_enabled_o |=>
        cfg_bar_o == ($past(cfg_wdata_i) & 32'hffff_f000))
        else $error("base register not written");
    a_disabled_quiet: assert property (!ram_enabled_o |-> cfg_bar_o == 32'h0 && !tgt_claim_o)
        else $error("disabled RAM visible");
    a_scratch_mirror: assert property (general_scratch_reg_two_o ==
        (chip_test_reg_two_i[3] ? cfg_bar_o : scratch_value_i))
        else $error("scratch mirror wrong");
    a_strap_kept: assert property (ram_enabled_o |=> ram_enabled_o)
        else $error("enable lost after capture");
endmodule : ipr_port_sva

bind ipr_port ipr_port_sva i_ipr_port_sva (.*);

// ---- verif/ipr_pci_host.sv ----
// Host model: configuration writes and target word accesses.
// Assumes the port samples its inputs on the rising clock edge.
`timescale 1ns/100ps

module ipr_pci_host (
    // Clock and completion
    input wire logic core_clk_i,
    input wire logic tgt_ready_o,
    input wire logic [31:0] tgt_rdata_o,
    // Configuration
    output logic cfg_wr_i,
    output logic [31:0] cfg_wdata_i,
    output logic mem_space_en_i,
    // Target access
    output logic tgt_req_i,
    output logic tgt_we_i,
    output logic [3:0] tgt_be_i,
    output logic [31:0] tgt_addr_i,
    output logic [31:0] tgt_wdata_i
);
    initial begin
        cfg_wr_i = 1'b0;
        cfg_wdata_i = 32'h0;
        mem_space_en_i = 1'b1;
        tgt_req_i = 1'b0;
        tgt_we_i = 1'b0;
        tgt_be_i = 4'h0;
        tgt_addr_i = 32'h0;
        tgt_wdata_i = 32'h0;
    end

    task automatic cfg(input logic [31:0] d);
        cfg_wr_i <= 1'b1;
        cfg_wdata_i <= d;
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
        cfg_wdata_i <= ~d;
        @(posedge core_clk_i);
    endtask : cfg

    // Holds the request until ready, gives up after 8 edges
    task automatic acc(input logic we, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q, output int n);
        n = 0;
        tgt_req_i <= 1'b1;
        tgt_we_i <= we;
        tgt_be_i <= be;
        tgt_addr_i <= a;
        tgt_wdata_i <= d;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (tgt_ready_o !== 1'b1 && n < 8);
        q = tgt_rdata_o;
        tgt_req_i <= 1'b0;
        tgt_we_i <= ~we;
        tgt_be_i <= ~be;
        tgt_addr_i <= ~a;
        tgt_wdata_i <= ~d;
        @(posedge core_clk_i);
    endtask : acc
endmodule : ipr_pci_host

// ---- verif/ipr_port_bench.sv ----
// Self-checking bench for the internal program RAM port.
// Assumes the host model drives configuration and target inputs.
`timescale 1ns/100ps

module ipr_port_bench;
    logic core_clk_i, rst_i, local_bus_strap_bit5_i, cfg_wr_i, mem_space_en_i;
    logic tgt_req_i, tgt_we_i, tgt_claim_o, tgt_busy_o, tgt_ready_o;
    logic seq_req_i, seq_internal_o, seq_to_bus_o, seq_ready_o, ram_enabled_o;
    logic [3:0] tgt_be_i;
    logic [7:0] chip_test_reg_two_i;
    logic [31:0] cfg_wdata_i, cfg_bar_o, scratch_value_i, general_scratch_reg_two_o;
    logic [31:0] tgt_addr_i, tgt_wdata_i, tgt_rdata_o, seq_addr_i, seq_rdata_o, q;
    ipr_pkg::ipr_kind_t seq_kind_i;
    int fail_count, check_count, n;
    localparam logic [31:0] BASE = 32'h1234_5000;

    ipr_port i_ipr_port (.*);
    ipr_pci_host i_ipr_pci_host (.*);

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input logic s);
        rst_i <= 1'b1;
        local_bus_strap_bit5_i <= s;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        chk({31'h0, ram_enabled_o}, {31'h0, s});
    endtask : do_reset

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_bar(input logic en);
        i_ipr_pci_host.cfg(32'h1234_5abc);
        chk(cfg_bar_o, en ? BASE : 32'h0);
        chip_test_reg_two_i <= 8'h08;
        scratch_value_i <= 32'h5a5a_0f0f;
        @(posedge core_clk_i);
        chk(general_scratch_reg_two_o, en ? BASE : 32'h0);
        chip_test_reg_two_i <= 8'hf7;
        @(posedge core_clk_i);
        chk(general_scratch_reg_two_o, 32'h5a5a_0f0f);
    endtask : t_bar

    task automatic t_mem();
        i_ipr_pci_host.acc(1'b1, BASE + 32'h10, 4'hf, 32'ha5a5_a5a5, q, n);
        chk(32'(n), 32'd5);
        i_ipr_pci_host.acc(1'b1, BASE + 32'h10, 4'h5, 32'h1122_3344, q, n);
        i_ipr_pci_host.acc(1'b0, BASE + 32'h10, 4'hf, 32'h0, q, n);
        chk(q, 32'ha522_a544);
        i_ipr_pci_host.acc(1'b1, BASE + 32'hffc, 4'hf, 32'hc0de_0001, q, n);
        i_ipr_pci_host.acc(1'b0, BASE + 32'hffc, 4'hf, 32'h0, q, n);
        chk(q, 32'hc0de_0001);
        i_ipr_pci_host.acc(1'b0, BASE + 32'h1000, 4'hf, 32'h0, q, n);
        chk(32'(n), 32'd8);
        i_ipr_pci_host.mem_space_en_i <= 1'b0;
        i_ipr_pci_host.acc(1'b0, BASE + 32'h10, 4'hf, 32'h0, q, n);
        chk(32'(n), 32'd8);
        i_ipr_pci_host.mem_space_en_i <= 1'b1;
    endtask : t_mem

    task automatic t_seq(input logic [31:0] a, input ipr_pkg::ipr_kind_t k,
                         input logic [31:0] d);
        logic f;
        f = (k != ipr_pkg::IPR_ACCESS_OTHER);
        seq_req_i <= 1'b1;
        seq_addr_i <= a;
        seq_kind_i <= k;
        @(posedge core_clk_i);
        chk({31'h0, seq_internal_o}, {31'h0, f});
        chk({31'h0, seq_to_bus_o}, {31'h0, !f});
        @(posedge core_clk_i);
        chk({31'h0, seq_ready_o}, {31'h0, f});
        if (f) chk(seq_rdata_o, d);
        seq_req_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : t_seq

    task automatic t_off();
        do_reset(1'b0);
        t_bar(1'b0);
        i_ipr_pci_host.acc(1'b0, 32'h10, 4'hf, 32'h0, q, n);
        chk(32'(n), 32'd8);
    endtask : t_off

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        local_bus_strap_bit5_i = 1'b1;
        chip_test_reg_two_i = 8'h00;
        scratch_value_i = 32'h0;
        seq_req_i = 1'b0;
        seq_addr_i = 32'h0;
        seq_kind_i = ipr_pkg::IPR_FETCH_INSTR;
        @(posedge core_clk_i);
        do_reset(1'b1);
        t_bar(1'b1);
        t_mem();
        t_seq(BASE + 32'h10, ipr_pkg::IPR_FETCH_INSTR, 32'ha522_a544);
        t_seq(BASE + 32'hffc, ipr_pkg::IPR_FETCH_TABLE, 32'hc0de_0001);
        t_seq(BASE + 32'h10, ipr_pkg::IPR_ACCESS_OTHER, 32'h0);
        t_off();
        tally_and_finish();
    end
endmodule : ipr_port_bench
